// ===== irq_ctrl_top.sv
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module irq_ctrl_top #(
  parameter int N = `IRQ_SOURCES
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [N-1:0] SRC_EVENT,
  input wire irq_ctrl_pkg::pend_ctl_t PEND_SW,
  input wire irq_ctrl_pkg::sfr_access_t SFR,
  input wire irq_ctrl_pkg::cpu_step_t STEP,
  output logic [7:0] SFR_RDATA,
  output logic [N-1:0] PENDING,
  output logic IRQ_REQ,
  output logic VEC_TAKE,
  output logic [15:0] VEC_ADDR,
  output logic [4:0] VEC_INDEX,
  output logic VEC_LEVEL,
  output logic SVC_LOW,
  output logic SVC_HIGH
);
  import irq_ctrl_pkg::*;

  logic [7:0] primary_enable_reg;
  logic [7:0] primary_level_reg;
  logic [7:0] ext_enable_reg_a;
  logic [7:0] ext_enable_reg_b;
  logic [7:0] ext_level_reg_a;
  logic [7:0] ext_level_reg_b;
  logic [N-1:0] pend;
  logic [N-1:0] en_prev;
  logic clear_window;
  svc_t svc;
  svc_t next_svc;

  // Flatten the enable and level bits into source order
  wire global_irq_gate = primary_enable_reg[`GATE_BIT]; // R6
  wire [N-1:0] en_raw = {ext_enable_reg_b[2:0], ext_enable_reg_a, primary_enable_reg[6:0]}; // R18
  wire [N-1:0] lvl_all = {ext_level_reg_b[2:0], ext_level_reg_a, primary_level_reg[6:0]}; // R18 R1
  wire [N-1:0] en_all = en_raw & {N{global_irq_gate}}; // R6

  // Detect a write that clears any enable; the old mask covers one following single-cycle step
  wire wr_pri = SFR.wr && (SFR.sel == `SEL_PRI_EN);
  wire wr_ea = SFR.wr && (SFR.sel == `SEL_EXT_EN_A);
  wire wr_eb = SFR.wr && (SFR.sel == `SEL_EXT_EN_B);
  wire clears_en = (wr_pri && |(primary_enable_reg & ~SFR.data))
    || (wr_ea && |(ext_enable_reg_a & ~SFR.data))
    || (wr_eb && |(ext_enable_reg_b[2:0] & ~SFR.data[2:0]));
  wire use_prev = clear_window && STEP.single; // R7
  wire [N-1:0] en_take = use_prev ? en_prev : en_all; // R7

  // Eligibility per level; disabled flags are simply ignored
  wire [N-1:0] elig = pend & en_take; // R3 R5
  wire [N-1:0] high_req = elig & lvl_all;
  wire [N-1:0] low_req = elig & ~lvl_all;
  wire high_ok = (svc == SVC_IDLE) || (svc == SVC_LO); // R11 R17
  wire low_ok = (svc == SVC_IDLE); // R17

  logic high_found;
  logic low_found;
  logic [4:0] high_idx;
  logic [4:0] low_idx;

  // Same fixed-order picker used for each level
  irq_pick #(.N(N), .W(5)) u_pick_high (
    .req(high_req),
    .found(high_found),
    .index(high_idx)
  );

  irq_pick #(.N(N), .W(5)) u_pick_low (
    .req(low_req),
    .found(low_found),
    .index(low_idx)
  );

  // High level beats low; lowest index within a level
  wire take_high = high_found && high_ok; // R12
  wire take_low = low_found && low_ok && !take_high; // R12 R13
  wire any_req = take_high || take_low;
  wire [4:0] pick_idx = take_high ? high_idx : low_idx; // R13
  // No call at the end of a return: one more instruction must finish first
  wire take_now = any_req && STEP.done && !STEP.return_from_irq_insn; // R3 R15 R9 R17 R16
  wire [15:0] pick_addr = `VEC_BASE + {8'h00, pick_idx, 3'h0}; // R13
  wire [N-1:0] pick_onehot = N'(1) << pick_idx;
  wire [N-1:0] auto_mask = `AUTO_CLEAR_MASK; // R8
  wire [N-1:0] auto_clr = take_now ? (pick_onehot & auto_mask) : '0; // R8
  // Set beats clear so an event in the clearing cycle survives
  wire [N-1:0] next_pend = (pend & ~PEND_SW.clr & ~auto_clr) | PEND_SW.set | SRC_EVENT; // R2 R10

  // Pending flags sampled every cycle
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      pend <= '0;
    else
      pend <= next_pend; // R2 R10 R14
  end

  // Enable and level registers; primary level bit 7 is hardwired high
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      primary_enable_reg <= `PRIMARY_RESET;
      primary_level_reg <= `LEVEL_RESET; // R19 R11
      ext_enable_reg_a <= `EXT_RESET;
      ext_enable_reg_b <= `EXT_RESET;
      ext_level_reg_a <= `EXT_RESET;
      ext_level_reg_b <= `EXT_RESET;
    end
    else if (SFR.wr)
    begin
      case (SFR.sel)
        `SEL_PRI_EN: primary_enable_reg <= SFR.data;
        `SEL_PRI_LVL: primary_level_reg <= {1'b1, SFR.data[6:0]}; // R19
        `SEL_EXT_EN_A: ext_enable_reg_a <= SFR.data;
        `SEL_EXT_EN_B: ext_enable_reg_b <= {5'h00, SFR.data[2:0]};
        `SEL_EXT_LVL_A: ext_level_reg_a <= SFR.data;
        `SEL_EXT_LVL_B: ext_level_reg_b <= {5'h00, SFR.data[2:0]};
        default: ;
      endcase
    end
  end

  // Shadow of the enables before a clearing write, held to the next boundary
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      clear_window <= 1'b0;
      en_prev <= '0;
    end
    else if (clears_en)
    begin
      clear_window <= 1'b1; // R7
      en_prev <= en_all;
    end
    else if (STEP.done)
      clear_window <= 1'b0;
  end

  // In-service tracking: call pushes a level, return pops the highest
  always_comb
  begin
    next_svc = svc;
    if (STEP.done && STEP.return_from_irq_insn)
    begin
      case (svc)
        SVC_BOTH: next_svc = SVC_LO; // R4 R20
        SVC_HI: next_svc = SVC_IDLE;
        SVC_LO: next_svc = SVC_IDLE;
        default: next_svc = SVC_IDLE;
      endcase
    end
    else if (take_now)
    begin
      case (svc)
        SVC_IDLE: next_svc = take_high ? SVC_HI : SVC_LO; // R20
        SVC_LO: next_svc = SVC_BOTH; // R11
        default: next_svc = svc;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      svc <= SVC_IDLE;
    else
      svc <= next_svc; // R20
  end

  // Call strobe and vector, registered toward the sequencer
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      VEC_TAKE <= 1'b0;
      VEC_ADDR <= `VEC_RESET; // R13
      VEC_INDEX <= 5'h00;
      VEC_LEVEL <= 1'b0;
      IRQ_REQ <= 1'b0;
    end
    else
    begin
      VEC_TAKE <= take_now; // R3 R14
      IRQ_REQ <= any_req;
      if (take_now)
      begin
        VEC_ADDR <= pick_addr; // R13
        VEC_INDEX <= pick_idx;
        VEC_LEVEL <= take_high;
      end
    end
  end

  // Read view; unused high pending bits read zero
  wire [7:0] rd_mux = (SFR.sel == `SEL_PRI_EN) ? primary_enable_reg
    : (SFR.sel == `SEL_PRI_LVL) ? primary_level_reg
    : (SFR.sel == `SEL_EXT_EN_A) ? ext_enable_reg_a
    : (SFR.sel == `SEL_EXT_EN_B) ? ext_enable_reg_b
    : (SFR.sel == `SEL_EXT_LVL_A) ? ext_level_reg_a
    : (SFR.sel == `SEL_EXT_LVL_B) ? ext_level_reg_b
    : (SFR.sel == `SEL_PENDING_LO) ? pend[7:0]
    : {6'h00, pend[17:16]};

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      SFR_RDATA <= 8'h00;
      PENDING <= '0;
      SVC_LOW <= 1'b0;
      SVC_HIGH <= 1'b0;
    end
    else
    begin
      SFR_RDATA <= rd_mux;
      PENDING <= next_pend;
      SVC_LOW <= next_svc[0];
      SVC_HIGH <= next_svc[1];
    end
  end

  // Checks on the live behaviour
  AST_EVENT_SETS_PENDING: assert property (@(posedge CLOCK) disable iff (RESET) // R2
    (|SRC_EVENT) |=> ((PENDING & $past(SRC_EVENT)) == $past(SRC_EVENT)))
    else $error("source event did not set its pending flag");

  AST_GATE_BLOCKS: assert property (@(posedge CLOCK) disable iff (RESET) // R6
    (!global_irq_gate && !use_prev) |=> !VEC_TAKE)
    else $error("call made with global gate closed");

  AST_NO_CALL_AFTER_RETURN: assert property (@(posedge CLOCK) disable iff (RESET) // R15
    (STEP.done && STEP.return_from_irq_insn) |=> !VEC_TAKE)
    else $error("call made at the end of a return");

  AST_HIGH_NOT_PREEMPTED: assert property (@(posedge CLOCK) disable iff (RESET) // R11
    svc[1] |=> !VEC_TAKE)
    else $error("high routine was preempted");

  AST_HIGH_FIRST: assert property (@(posedge CLOCK) disable iff (RESET) // R12
    (take_now && high_found && high_ok) |=> (VEC_TAKE && VEC_LEVEL))
    else $error("low request granted over a high one");

  AST_VECTOR_ADDR: assert property (@(posedge CLOCK) disable iff (RESET) // R13
    VEC_TAKE |-> (VEC_ADDR == (`VEC_BASE + {8'h00, VEC_INDEX, 3'h0}) && VEC_ADDR <= `VEC_LAST))
    else $error("vector address does not match index");

  AST_CALL_ON_BOUNDARY: assert property (@(posedge CLOCK) disable iff (RESET) // R3
    (any_req && STEP.done && !STEP.return_from_irq_insn) |=> VEC_TAKE ##1 !VEC_TAKE)
    else $error("eligible request not called at boundary");

  AST_AUTO_CLEAR: assert property (@(posedge CLOCK) disable iff (RESET) // R8
    (take_now && auto_mask[pick_idx] && !SRC_EVENT[pick_idx] && !PEND_SW.set[pick_idx])
    |=> !PENDING[$past(pick_idx)])
    else $error("auto-clear source still pending after call");

  AST_RETURN_RELEASES: assert property (@(posedge CLOCK) disable iff (RESET) // R4
    (STEP.done && STEP.return_from_irq_insn && svc == SVC_BOTH) |=> (SVC_LOW && !SVC_HIGH))
    else $error("return did not release the high level");

  AST_LEVEL_BIT_FIXED: assert property (@(posedge CLOCK) disable iff (RESET) // R19
    ($past(SFR.sel) == `SEL_PRI_LVL) |-> SFR_RDATA[`LEVEL_FIXED_BIT])
    else $error("level register bit 7 read as zero");

  AST_SET_BEATS_CLEAR: assert property (@(posedge CLOCK) disable iff (RESET) // R10
    (|PEND_SW.set) |=> ((PENDING & $past(PEND_SW.set)) == $past(PEND_SW.set)))
    else $error("software set did not raise its pending flag");

  AST_GATE_NO_REQ: assert property (@(posedge CLOCK) disable iff (RESET) // R6 R5
    (!global_irq_gate && !use_prev) |=> !IRQ_REQ)
    else $error("request raised with global gate closed");

  AST_LOW_WAITS: assert property (@(posedge CLOCK) disable iff (RESET) // R17
    (svc != SVC_IDLE && !high_found) |=> !VEC_TAKE)
    else $error("request served while an equal or higher routine runs");

  AST_CALL_SETS_LEVEL: assert property (@(posedge CLOCK) disable iff (RESET) // R20
    take_now |=> (VEC_LEVEL ? SVC_HIGH : SVC_LOW))
    else $error("call did not mark its level in service");

  AST_LAST_RETURN_IDLE: assert property (@(posedge CLOCK) disable iff (RESET) // R4
    (STEP.done && STEP.return_from_irq_insn && (svc == SVC_LO || svc == SVC_HI)) |=> (!SVC_LOW && !SVC_HIGH))
    else $error("return left a level in service");

  AST_CALL_TAKES_PICK: assert property (@(posedge CLOCK) disable iff (RESET) // R14
    take_now |=> (VEC_INDEX == $past(pick_idx)))
    else $error("call index differs from the decoded winner");

  COV_PREEMPT: cover property (@(posedge CLOCK) disable iff (RESET)
    svc == SVC_LO ##[1:50] svc == SVC_BOTH);

  COV_HIGH_OVER_LOW: cover property (@(posedge CLOCK) disable iff (RESET)
    take_now && take_high && low_found);

  COV_REENTER: cover property (@(posedge CLOCK) disable iff (RESET)
    (STEP.done && STEP.return_from_irq_insn && any_req) ##[1:20] VEC_TAKE);

  COV_WINDOW_TAKE: cover property (@(posedge CLOCK) disable iff (RESET)
    take_now && use_prev);

endmodule : irq_ctrl_top

// ===== irq_ctrl_map.svh
// Functional notes
// R1: Eighteen request sources, each set to exactly one of two priority levels.
// R2: A source event sets its pending flag whatever its enable bits say.
// R3: Enabled pending flag raises a request; a vector call follows instruction completion.
// R4: Return-from-interrupt resumes the interrupted flow and releases the active level.
// R5: A pending flag with its source disabled produces no request.
// R6: Individual enables count only while the global gate, primary enable bit 7, is 1.
// R7: After an enable-clearing write, a following single-cycle instruction may still be interrupted.
// R8: Vectoring clears pending only for both pins, both basic timers and CAN.
// R9: A flag still set after return-from-interrupt re-requests at once.
// R10: Software setting a pending flag behaves exactly like a hardware event.
// R11: Low routines preemptible by high requests; high never preempted; reset gives low.
// R12: Simultaneous requests: a high-level one is granted before any low-level one.
// R13: Lowest index wins within a level; vector 0x0003 plus 8n; reset vector 0x0000.
// R14: Requests sampled and decoded every cycle; fastest response 1 detect plus 4 call cycles.
// R15: With a request pending at return-from-interrupt, one more instruction completes first.
// R16: Worst response 18 cycles: detect, 5 return, 8 divide, 4 call.
// R17: Equal or higher active routine makes a request wait past its return plus one instruction.
// R18: Indices 0-6 primary bits 0-6, 7-14 first extended pair, 15-17 second pair bits 0-2.
// R19: Primary level bit 7 reads 1 and ignores writes; other bits reset to 0.
// R20: One in-service flag per level; set on vector call, highest cleared on return.
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

`define IRQ_SOURCES 18
`define VEC_BASE 16'h0003
`define VEC_LAST 16'h008b
`define VEC_RESET 16'h0000
`define VEC_STEP_SHIFT 3
`define GATE_BIT 7
`define LEVEL_FIXED_BIT 7
`define PRIMARY_RESET 8'h00
`define LEVEL_RESET 8'h80
`define EXT_RESET 8'h00
`define AUTO_CLEAR_MASK 18'h1000f
`define SEL_PRI_EN 3'h0
`define SEL_PRI_LVL 3'h1
`define SEL_EXT_EN_A 3'h2
`define SEL_EXT_EN_B 3'h3
`define SEL_EXT_LVL_A 3'h4
`define SEL_EXT_LVL_B 3'h5
`define SEL_PENDING_LO 3'h6
`define SEL_PENDING_HI 3'h7
`define DETECT_CYCLES 1
`define LONG_CALL_CYCLES 4
`define RETURN_CYCLES 5
`define DIVIDE_CYCLES 8

`endif

// ===== irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // One register access from the core's special-register port
  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic [7:0] data;
  } sfr_access_t;

  // Instruction boundary report from the sequencer
  typedef struct packed {
    logic done;
    logic return_from_irq_insn;
    logic single;
  } cpu_step_t;

  // Software pending-flag manipulation
  typedef struct packed {
    logic [17:0] set;
    logic [17:0] clr;
  } pend_ctl_t;

  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_LO = 2'b01, // Short names keep clear of the in-service output ports
    SVC_HI = 2'b10,
    SVC_BOTH = 2'b11
  } svc_t;

endpackage : irq_ctrl_pkg

// ===== irq_pick.sv
`timescale 1ns/1ps
// Fixed-order pick: lowest set index wins
module irq_pick #(
  parameter int N = 18,
  parameter int W = 5
) (
  input wire logic [N-1:0] req,
  output logic found,
  output logic [W-1:0] index
);

  // Scan downward so the lowest index is assigned last
  always_comb
  begin
    found = 1'b0;
    index = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        index = W'(i);
      end
    end
  end

endmodule : irq_pick

// ===== cpu_seq_model.sv
`timescale 1ns/1ps
// Sequencer stand-in: instructions of insn_len cycles, stalls for each vector call
module cpu_seq_model
  import irq_ctrl_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic VEC_TAKE,
  input wire logic [3:0] insn_len,
  input wire logic return_from_irq_insn_req,
  output cpu_step_t step
);
  logic [3:0] cnt;
  logic [1:0] call;
  // The take cycle plus three more form the long call, with no instruction ending
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      cnt <= 4'h1;
      call <= 2'h0;
    end
    else if (VEC_TAKE)
      call <= 2'h3;
    else if (call != 2'h0)
      call <= call - 2'h1;
    else if (cnt >= insn_len)
      cnt <= 4'h1;
    else
      cnt <= cnt + 4'h1;
  end
  // Completion is reported in the last cycle of each instruction
  assign step.done = !RESET && !VEC_TAKE && call == 2'h0 && cnt >= insn_len;
  assign step.return_from_irq_insn = return_from_irq_insn_req;
  assign step.single = insn_len == 4'h1;
endmodule : cpu_seq_model

// ===== two_level_vectored_irq_ctrl_test.sv
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module two_level_vectored_irq_ctrl_test;
  import irq_ctrl_pkg::*;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic [17:0] SRC_EVENT = '0;
  pend_ctl_t PEND_SW = '0;
  sfr_access_t SFR = '0;
  cpu_step_t STEP;
  logic [7:0] SFR_RDATA;
  logic [17:0] PENDING;
  logic IRQ_REQ, VEC_TAKE, VEC_LEVEL, SVC_LOW, SVC_HIGH;
  logic [15:0] VEC_ADDR;
  logic [4:0] VEC_INDEX;
  logic [3:0] insn_len = 4'h2;
  logic return_from_irq_insn_req = 1'b0;
  logic [31:0] seed = 32'h23386c60;
  int n_errors = 0;
  int n_tests = 0;
  int pend, en, lvl, svc, w;
  bit gate;
  bit stuck;

  irq_ctrl_top dut (.CLOCK(CLOCK), .RESET(RESET), .SRC_EVENT(SRC_EVENT), .PEND_SW(PEND_SW), .SFR(SFR),
    .STEP(STEP), .SFR_RDATA(SFR_RDATA), .PENDING(PENDING), .IRQ_REQ(IRQ_REQ), .VEC_TAKE(VEC_TAKE),
    .VEC_ADDR(VEC_ADDR), .VEC_INDEX(VEC_INDEX), .VEC_LEVEL(VEC_LEVEL), .SVC_LOW(SVC_LOW), .SVC_HIGH(SVC_HIGH));
  cpu_seq_model seq (.CLOCK(CLOCK), .RESET(RESET), .VEC_TAKE(VEC_TAKE), .insn_len(insn_len),
    .return_from_irq_insn_req(return_from_irq_insn_req), .step(STEP));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected winner: high level first, then lowest index; in-service levels block
  function automatic int want();
    int e;
    e = gate ? (pend & en) : 0;
    if (!svc[1])
      for (int i = 0; i < 18; i++)
        if (e[i] && lvl[i])
          return i;
    if (svc == 0)
      for (int i = 0; i < 18; i++)
        if (e[i])
          return i;
    return -1;
  endfunction : want

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge CLOCK);
    SFR = {1'b1, s, d};
    @(negedge CLOCK);
    SFR.wr = 1'b0;
  endtask : wr

  // Read data trails the select by one cycle
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    @(negedge CLOCK);
    SFR.sel = s;
    @(negedge CLOCK);
    `CHK("sfr_rdata", e, SFR_RDATA)
  endtask : rd

  task automatic wait_take(output bit got);
    got = 0;
    repeat (60)
    begin
      @(negedge CLOCK);
      if (VEC_TAKE === 1'b1)
      begin
        got = 1;
        break;
      end
    end
  endtask : wait_take

  // Return from the innermost routine; stuck sequencer ends the run
  task automatic do_return_from_irq_insn();
    int k;
    @(negedge CLOCK);
    return_from_irq_insn_req = 1'b1;
    insn_len = 4'h5;
    for (k = 0; k < 40 && !(STEP.done === 1'b1 && STEP.return_from_irq_insn === 1'b1); k++)
      @(negedge CLOCK);
    if (k == 40)
    begin
      n_errors++;
      stuck = 1'b1; // Callers stop and fall through to the closing report
    end
    @(negedge CLOCK);
    return_from_irq_insn_req = 1'b0;
    svc = svc[1] ? (svc & 1) : 0;
    `CHK("svc_after_return_from_irq_insn", svc[1:0], {SVC_HIGH, SVC_LOW})
  endtask : do_return_from_irq_insn

  // One random round: program with the gate shut, post events, then serve everything
  task automatic round();
    logic [31:0] a, b, c, d;
    bit got;
    a = rnd();
    b = rnd();
    c = rnd();
    d = rnd();
    wr(3'h0, 8'h00);
    gate = 0;
    @(negedge CLOCK);
    PEND_SW.clr = '1;
    @(negedge CLOCK);
    PEND_SW.clr = '0;
    wr(3'h1, {b[31], b[6:0]});
    wr(3'h2, a[14:7]);
    wr(3'h3, {a[31:27], a[17:15]});
    wr(3'h4, b[14:7]);
    wr(3'h5, {b[31:27], b[17:15]});
    wr(3'h0, {1'b0, a[6:0]});
    en = a[17:0];
    lvl = b[17:0];
    rd(3'h0, {1'b0, a[6:0]});
    rd(3'h1, {1'b1, b[6:0]});
    rd(3'h3, {5'h00, a[17:15]});
    rd(3'h5, {5'h00, b[17:15]});
    @(negedge CLOCK);
    SRC_EVENT = c[17:0];
    PEND_SW.set = d[17:0];
    @(negedge CLOCK);
    SRC_EVENT = '0;
    PEND_SW.set = '0;
    pend = c[17:0] | d[17:0];
    `CHK("pending_gated", pend[17:0], PENDING)
    wr(3'h0, {1'b1, a[6:0]});
    gate = 1;
    repeat (60)
    begin
      insn_len = 4'(2 + rnd() % 7);
      wait_take(got);
      w = want();
      if (got)
      begin
        `CHK("vec_index", w[4:0], VEC_INDEX)
        `CHK("vec_addr", 16'h0003 + 16'(w) * 16'h0008, VEC_ADDR)
        `CHK("vec_level", lvl[w], VEC_LEVEL)
        `CHK("irq_req_call", 1'b1, IRQ_REQ)
        svc |= lvl[w] ? 2 : 1;
        if (`AUTO_CLEAR_MASK >> w & 1)
          pend &= ~(1 << w);
        @(negedge CLOCK);
        `CHK("pending_vectored", pend[17:0], PENDING)
        `CHK("svc", svc[1:0], {SVC_HIGH, SVC_LOW})
        PEND_SW.clr = 18'h1 << w;
        @(negedge CLOCK);
        PEND_SW.clr = '0;
        pend &= ~(1 << w);
      end
      else
      begin
        `CHK("no_call", -1, w)
        `CHK("irq_req", 1'b0, IRQ_REQ)
        if (svc == 0)
          break;
        do_return_from_irq_insn();
        if (stuck)
          break;
      end
    end
  endtask : round

  // Enable-clearing write as source 0 posts: a single-cycle follower still calls, a longer one does not
  task automatic clear_race(input logic [3:0] len, input bit exp);
    bit got;
    wr(3'h0, 8'h00);
    @(negedge CLOCK);
    PEND_SW.clr = '1;
    insn_len = len;
    @(negedge CLOCK);
    PEND_SW.clr = '0;
    wr(3'h0, 8'h81);
    @(negedge CLOCK);
    SFR = {1'b1, 3'h0, 8'h00};
    SRC_EVENT = 18'h00001;
    @(negedge CLOCK);
    SFR.wr = 1'b0;
    SRC_EVENT = '0;
    wait_take(got);
    `CHK("clear_race_take", exp, got)
    if (got)
    begin
      `CHK("clear_race_index", 5'h00, VEC_INDEX)
      svc = lvl[0] ? 2 : 1;
      do_return_from_irq_insn();
    end
  endtask : clear_race

  initial
    forever #4 CLOCK = ~CLOCK;

  initial
  begin
    repeat (20) @(negedge CLOCK);
    RESET = 1'b0;
    `CHK("vec_addr_reset", 16'h0000, VEC_ADDR)
    rd(3'h1, 8'h80);
    rd(3'h0, 8'h00);
    for (int r = 0; r < 40 && !stuck; r++)
      round();
    if (!stuck)
    begin
      clear_race(4'h1, 1'b1);
      clear_race(4'h2, 1'b0);
    end
    end_of_test();
  end
endmodule : two_level_vectored_irq_ctrl_test
